// *** src/opc_pkg.sv ***
// Constants for the optical pulse configuration register bank.
// Assumes an 8-bit register port with 8-bit addresses from the serial link.
package opc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OPC_ADDR_GAIN    = 8'h2E;
    localparam logic [7:0] OPC_ADDR_CFG     = 8'h2F;
    localparam logic [7:0] OPC_ADDR_IR_LOW  = 8'h30;
    localparam logic [7:0] OPC_ADDR_IR_HIGH = 8'h31;

    localparam logic [7:0] OPC_RST_GAIN     = 8'h09;
    localparam logic [7:0] OPC_RST_CFG      = 8'h40;
    localparam logic [7:0] OPC_RST_IR       = 8'h00;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int OPC_GAIN_LSB   = 4;
    localparam int OPC_SAVE_BIT   = 6;
    localparam int OPC_SWAP_BIT   = 3;
    localparam int OPC_IR_W       = 10;
    localparam logic [7:0] OPC_GAIN_FIXED   = 8'h09;
    localparam logic [7:0] OPC_GAIN_WMASK   = 8'h30;
    localparam logic [7:0] OPC_CFG_WMASK    = 8'h48;
    localparam logic [7:0] OPC_IRH_WMASK    = 8'h03;

    // ****************************************************************
    // Gain modes, idle time threshold
    // ****************************************************************
    typedef enum logic [1:0] {
        OPC_GAIN_X1   = 2'b00,
        OPC_GAIN_X1P5 = 2'b01,
        OPC_GAIN_X2   = 2'b10,
        OPC_GAIN_X4   = 2'b11
    } opc_gain_e;

    localparam int OPC_CLK_MHZ       = 125;
    localparam int OPC_IDLE_MIN_US   = 50;
    localparam int OPC_IDLE_MIN_CYC  = OPC_IDLE_MIN_US * OPC_CLK_MHZ;

endpackage : opc_pkg

// *** src/opc_config_regs.sv ***
// Configuration registers of the optical pulse / proximity engine.
// Assumes the serial link decoder presents single-cycle write and read strobes.
// Contract
// - Gain field bits 5:4 selects gain mode
// - Gain register resets to 0x09
// - Power save only when idle at least 50us
// - Power save bit resets to one
// - Swap zero: infrared first, red second
// - Swap one: red first, infrared second
// - Ten-bit current split low byte, high bits
// - Code 0x3FF gives nominal full current
// - Single mode one sample, dual two samples
`timescale 1ns/1ps
`default_nettype none
module opc_config_regs
    import opc_pkg::*;
#(
    parameter int IDLE_MIN_CYC = OPC_IDLE_MIN_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    input  wire logic        dual_emitter_pulse_mode,
    input  wire logic        meas_start,
    input  wire logic        meas_active,
    input  wire logic        sample_index,
    output logic      [1:0]  measure_gain_range,
    output logic             ir_emitter_pin,
    output logic             red_emitter_pin,
    output logic      [9:0]  ir_drive_code,
    output logic             analog_power_down,
    output logic      [1:0]  samples_per_period
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]  gain_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  ir_low_reg;
    logic [7:0]  ir_high_reg;
    logic [13:0] idle_cnt_reg;
    logic [13:0] idle_cnt_next;

    // Only the documented fields are writable; fixed bits hold their pattern
    // so a careless write cannot corrupt them.
    wire hit_gain = (reg_addr == OPC_ADDR_GAIN);
    wire hit_cfg  = (reg_addr == OPC_ADDR_CFG);
    wire hit_irl  = (reg_addr == OPC_ADDR_IR_LOW);
    wire hit_irh  = (reg_addr == OPC_ADDR_IR_HIGH);
    wire [7:0] gain_wval = (reg_wdata & OPC_GAIN_WMASK) | OPC_GAIN_FIXED;
    wire [7:0] cfg_wval  = reg_wdata & OPC_CFG_WMASK;
    wire [7:0] irh_wval  = reg_wdata & OPC_IRH_WMASK;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_reg    <= OPC_RST_GAIN;
            cfg_reg     <= OPC_RST_CFG;
            ir_low_reg  <= OPC_RST_IR;
            ir_high_reg <= OPC_RST_IR;
        end else if (clk_en && reg_wr) begin
            if (hit_gain) gain_reg    <= gain_wval;
            if (hit_cfg)  cfg_reg     <= cfg_wval;
            if (hit_irl)  ir_low_reg  <= reg_wdata;
            if (hit_irh)  ir_high_reg <= irh_wval;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire [7:0] rd_mux = hit_gain ? gain_reg :
                        hit_cfg  ? cfg_reg :
                        hit_irl  ? ir_low_reg :
                        hit_irh  ? ir_high_reg : 8'h00;
    assign reg_hit = hit_gain | hit_cfg | hit_irl | hit_irh;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ****************************************************************
    // Engine controls
    // ****************************************************************
    assign measure_gain_range = gain_reg[OPC_GAIN_LSB +: 2];
    // Code is linear: the analog DAC scales 0..0x3FF onto 0..full current
    assign ir_drive_code = {ir_high_reg[1:0], ir_low_reg};

    wire swap     = cfg_reg[OPC_SWAP_BIT];
    // Second dual sample uses the other emitter
    wire use_red  = swap ^ (dual_emitter_pulse_mode & sample_index);
    assign ir_emitter_pin  = meas_active & ~use_red;
    assign red_emitter_pin = meas_active &  use_red;
    assign samples_per_period = dual_emitter_pulse_mode ? 2'd2 : 2'd1;

    // Idle time is counted after each pulse; power down only once it
    // is known the gap reaches the minimum, so short gaps stay powered.
    wire idle_long = (idle_cnt_reg >= 14'(IDLE_MIN_CYC));
    always_comb begin
        idle_cnt_next = idle_cnt_reg;
        if (meas_active || meas_start)
            idle_cnt_next = 14'h0000;
        else if (!idle_long)
            idle_cnt_next = idle_cnt_reg + 14'h0001;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) idle_cnt_reg <= 14'h0000;
        else if (clk_en) idle_cnt_reg <= idle_cnt_next;
    end

    assign analog_power_down = cfg_reg[OPC_SAVE_BIT] & idle_long & ~meas_active;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_gain_fixed: assert property (@(posedge mclk) disable iff (rst)
        gain_reg[3:0] == OPC_GAIN_FIXED[3:0] && gain_reg[7:6] == 2'b00)
        else $error("gain fixed bits corrupted");
    a_gain_write: assert property (@(posedge mclk) disable iff (rst)
        clk_en && reg_wr && hit_gain |=> measure_gain_range == $past(reg_wdata[5:4]))
        else $error("gain field not updated");
    a_gain_reset: assert property (@(posedge mclk) $fell(rst) |-> gain_reg == OPC_RST_GAIN)
        else $error("gain reset value wrong");
    a_save_reset: assert property (@(posedge mclk) $fell(rst) |-> cfg_reg[OPC_SAVE_BIT])
        else $error("power save not set after reset");
    a_save_gate: assert property (@(posedge mclk) disable iff (rst)
        analog_power_down |-> cfg_reg[OPC_SAVE_BIT] && idle_cnt_reg >= 14'(IDLE_MIN_CYC))
        else $error("power down without long idle");
    a_save_busy: assert property (@(posedge mclk) disable iff (rst)
        meas_active |-> !analog_power_down)
        else $error("power down during a pulse");
    a_emit_plain: assert property (@(posedge mclk) disable iff (rst)
        meas_active && !cfg_reg[OPC_SWAP_BIT] && !(dual_emitter_pulse_mode && sample_index)
        |-> ir_emitter_pin && !red_emitter_pin)
        else $error("infrared emitter not chosen");
    a_emit_second: assert property (@(posedge mclk) disable iff (rst)
        meas_active && dual_emitter_pulse_mode && sample_index
        |-> ir_emitter_pin == cfg_reg[OPC_SWAP_BIT] && red_emitter_pin != cfg_reg[OPC_SWAP_BIT])
        else $error("second dual sample emitter wrong");
    a_emit_swap: assert property (@(posedge mclk) disable iff (rst)
        meas_active && cfg_reg[OPC_SWAP_BIT] && !(dual_emitter_pulse_mode && sample_index)
        |-> red_emitter_pin && !ir_emitter_pin)
        else $error("red emitter not chosen");
    a_ir_code: assert property (@(posedge mclk) disable iff (rst)
        clk_en && reg_wr && hit_irl |=> ir_drive_code[7:0] == $past(reg_wdata))
        else $error("current low byte not applied");
    a_ir_high: assert property (@(posedge mclk) disable iff (rst)
        ir_drive_code[9:8] == ir_high_reg[1:0] && ir_high_reg[7:2] == 6'h00)
        else $error("current high bits wrong");
    a_samples: assert property (@(posedge mclk) disable iff (rst)
        samples_per_period == (dual_emitter_pulse_mode ? 2'd2 : 2'd1))
        else $error("sample count wrong");
    a_ir_reset: assert property (@(posedge mclk) $fell(rst) |-> ir_drive_code == 10'h000)
        else $error("current code not zero after reset");
    a_cfg_fixed: assert property (@(posedge mclk) disable iff (rst)
        (cfg_reg & ~OPC_CFG_WMASK) == 8'h00)
        else $error("config fixed bits corrupted");
    // Low enable must hold all four config registers and the read data
    a_freeze_hold: assert property (@(posedge mclk) disable iff (rst)
        !clk_en |=> $stable(gain_reg) && $stable(cfg_reg) && $stable(ir_low_reg)
        && $stable(ir_high_reg) && $stable(reg_rdata))
        else $error("state changed while frozen");
    a_unmapped_rd: assert property (@(posedge mclk) disable iff (rst)
        clk_en && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    c_swap_dual: cover property (@(posedge mclk) disable iff (rst)
        meas_active && cfg_reg[3] && dual_emitter_pulse_mode && sample_index);
    c_power_down: cover property (@(posedge mclk) disable iff (rst) $rose(analog_power_down));
    c_full_code: cover property (@(posedge mclk) disable iff (rst) ir_drive_code == 10'h3FF);
    c_gain_x4: cover property (@(posedge mclk) disable iff (rst) measure_gain_range == 2'b11);

endmodule : opc_config_regs
`default_nettype wire

// *** verif/opc_engine_model.sv ***
// Behavioural measurement engine that drives the emitter timing inputs.
// Assumes one fire pulse from the bench per sample: one per period in single mode, two in dual mode.
`timescale 1ns/1ps
`default_nettype none
module opc_engine_model (
    input  wire logic mclk,
    input  wire logic fire,
    input  wire logic idx,
    output logic      meas_start,
    output logic      meas_active,
    output logic      sample_index
);
    logic [2:0] cnt_reg = 3'h0;
    initial begin
        meas_start   = 1'b0;
        sample_index = 1'b0;
    end
    // Four-cycle pulse per sample; index tells first or second of the period
    always @(posedge mclk) begin
        meas_start <= fire;
        if (fire) begin
            sample_index <= idx;
            cnt_reg      <= 3'h4;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    assign meas_active = (cnt_reg != 3'h0);
endmodule : opc_engine_model
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the optical pulse configuration registers.
// Assumes the engine model drives the timing inputs; clk_en is held high except for one frozen write and read.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import opc_pkg::*;
    localparam int IDLE = 20;
    logic mclk = 0, rst = 1, wr_s = 0, rd_s = 0, fire = 0, idx = 0, dual = 0, en = 1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic hit, ir_pin, red_pin, pdn, mstart, mact, sidx;
    logic [1:0] gain, spp;
    logic [9:0] code;
    int mismatches = 0;
    int compares = 0;
    opc_config_regs #(.IDLE_MIN_CYC(IDLE)) opc_config_regs_inst (.mclk(mclk), .rst(rst),
        .clk_en(en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdata), .reg_hit(hit), .dual_emitter_pulse_mode(dual),
        .meas_start(mstart), .meas_active(mact), .sample_index(sidx),
        .measure_gain_range(gain), .ir_emitter_pin(ir_pin), .red_emitter_pin(red_pin),
        .ir_drive_code(code), .analog_power_down(pdn), .samples_per_period(spp));
    opc_engine_model opc_engine_model_inst (.mclk(mclk), .fire(fire), .idx(idx),
        .meas_start(mstart), .meas_active(mact), .sample_index(sidx));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 wr_s = 1;
        addr = a;
        wdata = d;
        @(posedge mclk);
        #1 wr_s = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1 rd_s = 1;
        addr = a;
        @(posedge mclk);
        #1 rd_s = 0;
        chk("rdata", 10'(e), 10'(rdata));
    endtask : rd
    // Checks pins in the first pulse cycle, then lets the pulse end and a short idle pass
    task automatic pl(input logic i, input logic e_ir, input logic e_red);
        @(posedge mclk);
        #1 fire = 1;
        idx = i;
        @(posedge mclk);
        #1 fire = 0;
        chk("ir_pin", 10'(e_ir), 10'(ir_pin));
        chk("red_pin", 10'(e_red), 10'(red_pin));
        repeat (6) @(posedge mclk);
        #1;
    endtask : pl
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    // Bound on the whole run so a hang still reaches the verdict
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge mclk);
        #1 rst = 0;
        rd(OPC_ADDR_GAIN, 8'h09);
        rd(OPC_ADDR_CFG, 8'h40);
        rd(OPC_ADDR_IR_LOW, 8'h00);
        rd(OPC_ADDR_IR_HIGH, 8'h00);
        for (int g = 0; g < 4; g++) begin
            wr(OPC_ADDR_GAIN, 8'h09 | 8'(g << 4));
            chk("gain", 10'(g), 10'(gain));
            rd(OPC_ADDR_GAIN, 8'h09 | 8'(g << 4));
        end
        // Fixed bits are forced; then a frozen enable must drop the write and the read
        wr(OPC_ADDR_GAIN, 8'hE6);
        rd(OPC_ADDR_GAIN, 8'h29);
        en = 0;
        wr(OPC_ADDR_GAIN, 8'h09);
        chk("gain", 10'h002, 10'(gain));
        rd(OPC_ADDR_CFG, 8'h29);
        en = 1;
        wr(OPC_ADDR_GAIN, 8'h09);
        chk("gain", 10'h000, 10'(gain));
        wr(OPC_ADDR_IR_LOW, 8'hFF);
        wr(OPC_ADDR_IR_HIGH, 8'h03);
        chk("code", 10'h3FF, code);
        wr(OPC_ADDR_IR_HIGH, 8'h01);
        chk("code", 10'h1FF, code);
        wr(OPC_ADDR_IR_LOW, 8'h01);
        wr(OPC_ADDR_IR_HIGH, 8'h00);
        chk("code", 10'h001, code);
        rd(8'h40, 8'h00);
        chk("hit", 10'h000, 10'(hit));
        dual = 1;
        #1 chk("spp", 10'h002, 10'(spp));
        pl(0, 1, 0);
        pl(1, 0, 1);
        wr(OPC_ADDR_CFG, 8'h48);
        pl(0, 0, 1);
        pl(1, 1, 0);
        dual = 0;
        #1 chk("spp", 10'h001, 10'(spp));
        pl(0, 0, 1);
        chk("pdn", 10'h000, 10'(pdn));
        repeat (IDLE + 10) @(posedge mclk);
        #1 chk("pdn", 10'h001, 10'(pdn));
        wr(OPC_ADDR_CFG, 8'h08);
        chk("pdn", 10'h000, 10'(pdn));
        rst = 1;
        repeat (2) @(posedge mclk);
        #1 rst = 0;
        rd(OPC_ADDR_CFG, 8'h40);
        rd(OPC_ADDR_IR_LOW, 8'h00);
        chk("code", 10'h000, code);
        stop_test;
    end
endmodule : tb
`default_nettype wire
